// ---- design/mbx_bridge.sv ----
// mbx_bridge: extended-mode mailbox between the reader and the host port
`timescale 1ns/1ps
module mbx_bridge
    import mbx_pkg::*;
(
    // clock and reset
    input  wire logic              sys_clk,
    input  wire logic              rstn,
    // mode selection
    input  wire logic              ext_mode_en,
    input  wire logic              tun_mode_en,
    input  wire logic              rf_field_on,
    // decoded reader commands
    input  wire logic              rf_cmd_valid,
    input  wire logic              rf_cmd_write,
    input  wire logic              rf_frame_err,
    input  wire logic [7:0]        rf_addr,
    input  wire logic [31:0]       rf_wdata,
    // reader answers
    output logic                   rf_rsp_valid,
    output mbx_rsp_t               rf_rsp_code,
    output logic [127:0]           rf_rsp_data,
    // host commands and buffer access
    input  wire logic              host_cmd_valid,
    input  wire mbx_cmd_t          host_cmd,
    input  wire logic              host_wr_valid,
    input  wire logic              host_rd_valid,
    input  wire logic [1:0]        host_idx,
    input  wire logic [31:0]       host_wdata,
    output logic                   host_rd_done,
    output logic [31:0]            host_rd_data,
    // events and status
    output logic                   rx_start_irq,
    output logic                   rx_end_irq,
    output logic                   tx_end_irq,
    output logic                   acc_err_irq,
    output logic [7:0]             mbx_flags,
    output logic                   reader_owns_buf
);

    // ************************************************************
    // state and storage
    // ************************************************************
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RX,
        ST_RX_RDY,
        ST_TX_RDY
    } mbx_state_t;

    mbx_state_t          st_r, st_nxt;
    logic                pend_r, pend_nxt;
    logic                fld_s1_r, fld_s2_r, fld_s3_r;
    logic [3:0]          we;
    logic                clr;
    logic [MBX_WORD_W-1:0] wdat;
    logic [MBX_WORD_W-1:0] word [MBX_WORDS];
    mbx_rsp_t            rsp_nxt;
    logic                rxs_nxt, rxe_nxt, txe_nxt, acc_nxt;

    // field is asynchronous to sys_clk
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            fld_s1_r <= 1'b0;
            fld_s2_r <= 1'b0;
            fld_s3_r <= 1'b0;
        end else begin
            fld_s1_r <= rf_field_on;
            fld_s2_r <= fld_s1_r;
            fld_s3_r <= fld_s2_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < MBX_WORDS; gi++) begin : g_buf
            mbx_word #(.W(MBX_WORD_W)) u_word (
                .sys_clk (sys_clk),
                .rstn    (rstn),
                .clr     (clr),
                .we      (we[gi]),
                .d       (wdat),
                .q       (word[gi])
            );
        end
    endgenerate

    // ************************************************************
    // decode
    // ************************************************************
    wire        field_rise = fld_s2_r & ~fld_s3_r;
    wire        ext_act    = ext_mode_en & ~tun_mode_en;
    wire        mbx_addr   = rf_addr >= MBX_ADDR_FIRST;
    wire        rf_read    = rf_cmd_valid & ~rf_cmd_write;
    wire        buf_empty  = (st_r == ST_IDLE) & ~pend_r;
    wire        host_req   = host_cmd_valid | host_wr_valid
                           | host_rd_valid;
    // reader wins a same-cycle clash; the host is told to retry
    wire        host_go    = host_req & ~rf_cmd_valid
                           & ~field_rise;
    wire        host_rd_ok = host_rd_valid & host_go
                           & ~host_cmd_valid & ~host_wr_valid
                           & (st_r != ST_RX);
    wire [7:0]  flags_now;
    assign flags_now[MBX_FLG_HOST_RDY]  = st_r == ST_TX_RDY;
    assign flags_now[MBX_FLG_HOST_PEND] = pend_r;
    assign flags_now[MBX_FLG_RD_ACTIVE] = st_r == ST_RX;
    assign flags_now[MBX_FLG_RD_RDY]    = st_r == ST_RX_RDY;
    assign flags_now[7:4]               = 4'h0;
    wire [95:0] tx_words  = (st_r == ST_TX_RDY) ?
                            {word[2], word[1], word[0]} : 96'h0;
    wire [127:0] rd_block = {24'h00_0000, flags_now, tx_words};
    assign wdat = rf_cmd_valid ? rf_wdata : host_wdata;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        st_nxt   = st_r;
        pend_nxt = pend_r;
        rsp_nxt  = MBX_RSP_NONE;
        we       = 4'h0;
        clr      = 1'b0;
        rxs_nxt  = 1'b0;
        rxe_nxt  = 1'b0;
        txe_nxt  = 1'b0;
        acc_nxt  = host_req & ~host_go;
        if (field_rise) begin
            st_nxt   = ST_IDLE;
            pend_nxt = 1'b0;
            clr      = 1'b1;
        end else if (rf_cmd_valid) begin
            if (!ext_act) begin
                rsp_nxt = MBX_RSP_EEPROM;
            end else if (rf_frame_err) begin
                rsp_nxt = MBX_RSP_NONE;
            end else if (!mbx_addr) begin
                rsp_nxt = MBX_RSP_EEPROM;
                if (rf_cmd_write && !buf_empty) begin
                    st_nxt   = ST_IDLE;
                    pend_nxt = 1'b0;
                    clr      = 1'b1;
                end
            end else if (rf_read) begin
                rsp_nxt = (rf_addr == MBX_ADDR_FIRST) ?
                          MBX_RSP_DATA : MBX_RSP_NAK;
            end else begin
                rsp_nxt = MBX_RSP_NAK;
                case (rf_addr)
                    MBX_ADDR_FIRST: begin
                        if (buf_empty || st_r == ST_RX) begin
                            we[0]   = 1'b1;
                            st_nxt  = ST_RX;
                            rxs_nxt = buf_empty;
                            rsp_nxt = MBX_RSP_ACK;
                        end
                    end
                    MBX_ADDR_MID1, MBX_ADDR_MID2: begin
                        if (st_r == ST_RX) begin
                            we[rf_addr[1:0]] = 1'b1;
                            rsp_nxt = MBX_RSP_ACK;
                        end
                    end
                    default: begin
                        if (st_r == ST_RX) begin
                            we[3]   = 1'b1;
                            st_nxt  = ST_RX_RDY;
                            rxe_nxt = 1'b1;
                            rsp_nxt = MBX_RSP_ACK;
                        end else if (st_r == ST_TX_RDY) begin
                            st_nxt  = ST_IDLE;
                            clr     = 1'b1;
                            txe_nxt = 1'b1;
                            rsp_nxt = MBX_RSP_ACK;
                        end
                    end
                endcase
            end
        end else if (host_go && host_cmd_valid) begin
            case (host_cmd)
                MBX_CMD_CLEAR: begin
                    if (st_r == ST_IDLE || st_r == ST_RX_RDY) begin
                        st_nxt   = ST_IDLE;
                        pend_nxt = 1'b1;
                        clr      = 1'b1;
                    end else begin
                        acc_nxt  = 1'b1;
                    end
                end
                MBX_CMD_TRANSMIT: begin
                    if (st_r == ST_IDLE) begin
                        st_nxt   = ST_TX_RDY;
                        pend_nxt = 1'b0;
                    end else begin
                        acc_nxt  = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (host_go && host_wr_valid) begin
            if (st_r == ST_IDLE && host_idx < MBX_IDX_FLAGS) begin
                we[host_idx] = 1'b1;
                pend_nxt     = 1'b1;
            end else begin
                acc_nxt      = 1'b1;
            end
        end else if (host_rd_valid && host_go && !host_rd_ok) begin
            acc_nxt = 1'b1;
        end
    end

    // ************************************************************
    // registers and outputs
    // ************************************************************
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            st_r   <= ST_IDLE;
            pend_r <= 1'b0;
        end else begin
            st_r   <= st_nxt;
            pend_r <= pend_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rf_rsp_valid    <= 1'b0;
            rf_rsp_code     <= MBX_RSP_NONE;
            rf_rsp_data     <= 128'h0;
            rx_start_irq    <= 1'b0;
            rx_end_irq      <= 1'b0;
            tx_end_irq      <= 1'b0;
            acc_err_irq     <= 1'b0;
            mbx_flags       <= MBX_FLAGS_RST;
            reader_owns_buf <= 1'b0;
        end else begin
            rf_rsp_valid    <= rf_cmd_valid & ~field_rise;
            rf_rsp_code     <= rsp_nxt;
            if (rsp_nxt == MBX_RSP_DATA) begin
                rf_rsp_data <= rd_block;
            end
            rx_start_irq    <= rxs_nxt;
            rx_end_irq      <= rxe_nxt;
            tx_end_irq      <= txe_nxt;
            acc_err_irq     <= acc_nxt;
            mbx_flags       <= {4'h0, st_nxt == ST_RX_RDY,
                                st_nxt == ST_RX, pend_nxt,
                                st_nxt == ST_TX_RDY};
            reader_owns_buf <= (st_nxt == ST_RX)
                             | (st_nxt == ST_TX_RDY);
        end
    end

    // host read returns the word stored at that slot, 00h first
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            host_rd_done <= 1'b0;
            host_rd_data <= 32'h0000_0000;
        end else begin
            host_rd_done <= host_rd_ok;
            if (host_rd_ok) begin
                host_rd_data <= word[host_idx];
            end
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    wire rf_ok_wr = rf_cmd_valid & rf_cmd_write & ext_act
                  & ~rf_frame_err & ~field_rise;

    rx_start_a: assert property (rf_ok_wr && rf_addr == MBX_ADDR_FIRST
        && buf_empty |=> rx_start_irq && reader_owns_buf
        && mbx_flags[MBX_FLG_RD_ACTIVE])
        else $error("rx start not raised");
    host_block_a: assert property (st_r == ST_RX && host_wr_valid
        && !rf_cmd_valid |=> acc_err_irq && !host_rd_done)
        else $error("host access not blocked");
    early_last_a: assert property (rf_ok_wr && rf_addr == MBX_ADDR_LAST
        && st_r == ST_IDLE |=> rf_rsp_code == MBX_RSP_NAK
        && !rx_end_irq)
        else $error("early last block not refused");
    msg_ready_a: assert property (rf_ok_wr && rf_addr == MBX_ADDR_LAST
        && st_r == ST_RX |=> rx_end_irq
        && mbx_flags[MBX_FLG_RD_RDY] ##1 !rx_end_irq)
        else $error("message ready not set");
    ready_nak_a: assert property (rf_ok_wr && mbx_addr
        && st_r == ST_RX_RDY |=> rf_rsp_code == MBX_RSP_NAK
        && $stable(word[0]))
        else $error("write accepted while ready");
    tx_end_a: assert property (rf_ok_wr && rf_addr == MBX_ADDR_LAST
        && st_r == ST_TX_RDY |=> tx_end_irq && mbx_flags == 8'h00
        && word[0] == 32'h0000_0000)
        else $error("release did not end transmit");
    zero_read_a: assert property (rf_cmd_valid && !rf_cmd_write
        && ext_act && !rf_frame_err && rf_addr == MBX_ADDR_FIRST
        && st_r != ST_TX_RDY && !field_rise |=>
        rf_rsp_code == MBX_RSP_DATA && rf_rsp_data[95:0] == 96'h0)
        else $error("early read not zero");
    bad_read_a: assert property (rf_cmd_valid && !rf_cmd_write
        && ext_act && !rf_frame_err && mbx_addr && !field_rise
        && rf_addr != MBX_ADDR_FIRST |=> rf_rsp_code == MBX_RSP_NAK)
        else $error("bad read not refused");
    crc_drop_a: assert property (rf_cmd_valid && ext_act
        && rf_frame_err && !field_rise |=> rf_rsp_code == MBX_RSP_NONE
        && $stable(st_r) && $stable(word[3]))
        else $error("bad frame reached buffer");
    field_clr_a: assert property (fld_s2_r && !fld_s3_r |=>
        st_r == ST_IDLE && !pend_r && word[1] == 32'h0000_0000)
        else $error("field cycle kept buffer");
    tunnel_a: assert property (rf_cmd_valid && tun_mode_en
        && !field_rise |=> rf_rsp_code == MBX_RSP_EEPROM
        && $stable(st_r))
        else $error("mailbox active in transparent mode");
    discard_a: assert property (rf_ok_wr && !mbx_addr && !buf_empty
        |=> rf_rsp_code == MBX_RSP_EEPROM && st_r == ST_IDLE)
        else $error("interleaved write kept buffer");

    rx_msg_c: cover property (rx_start_irq ##[1:20] rx_end_irq);
    tx_msg_c: cover property (st_r == ST_TX_RDY ##[1:20] tx_end_irq);
    acc_err_c: cover property (acc_err_irq && st_r == ST_TX_RDY);

endmodule

// ---- design/mbx_pkg.sv ----
// mbx_pkg: constants and types shared by the reader/host mailbox bridge
package mbx_pkg;

    // ************************************************************
    // block addresses seen by the reader
    // ************************************************************
    localparam logic [7:0] MBX_ADDR_FIRST = 8'hFC;
    localparam logic [7:0] MBX_ADDR_MID1  = 8'hFD;
    localparam logic [7:0] MBX_ADDR_MID2  = 8'hFE;
    localparam logic [7:0] MBX_ADDR_LAST  = 8'hFF;

    // ************************************************************
    // buffer geometry
    // ************************************************************
    localparam int unsigned MBX_WORD_W    = 32;
    localparam int unsigned MBX_WORDS     = 4;
    localparam int unsigned MBX_TX_WORDS  = 3;
    localparam logic [1:0]  MBX_IDX_FLAGS = 2'h3;

    // ************************************************************
    // flags byte layout and reset value
    // ************************************************************
    localparam int unsigned MBX_FLG_HOST_RDY  = 0;
    localparam int unsigned MBX_FLG_HOST_PEND = 1;
    localparam int unsigned MBX_FLG_RD_ACTIVE = 2;
    localparam int unsigned MBX_FLG_RD_RDY    = 3;
    localparam logic [7:0]  MBX_FLAGS_RST     = 8'h00;

    // ************************************************************
    // host commands and reader answers
    // ************************************************************
    typedef enum logic [1:0] {
        MBX_CMD_NOP,
        MBX_CMD_CLEAR,
        MBX_CMD_TRANSMIT
    } mbx_cmd_t;

    typedef enum logic [2:0] {
        MBX_RSP_NONE,
        MBX_RSP_ACK,
        MBX_RSP_NAK,
        MBX_RSP_DATA,
        MBX_RSP_EEPROM
    } mbx_rsp_t;

endpackage

// ---- design/mbx_word.sv ----
// mbx_word: one word slot of the mailbox buffer
`timescale 1ns/1ps
module mbx_word #(
    parameter int unsigned W = 32
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         rstn,
    // control
    input  wire logic         clr,
    input  wire logic         we,
    input  wire logic [W-1:0] d,
    // stored word
    output logic      [W-1:0] q
);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (clr) begin
            q <= '0;
        end else if (we) begin
            q <= d;
        end
    end

endmodule

// ---- bench/mbx_reader_model.sv ----
// mbx_reader_model: behavioural contactless reader issuing block commands
`timescale 1ns/1ps
module mbx_reader_model
    import mbx_pkg::*;
(
    // clock
    input  wire logic         sys_clk,
    // commands towards the bridge
    output logic              rf_cmd_valid,
    output logic              rf_cmd_write,
    output logic              rf_frame_err,
    output logic [7:0]        rf_addr,
    output logic [31:0]       rf_wdata,
    // answers from the bridge
    input  wire logic         rf_rsp_valid,
    input  wire mbx_rsp_t     rf_rsp_code,
    input  wire logic [127:0] rf_rsp_data
);
    initial begin
        rf_cmd_valid = 1'b0;
        rf_cmd_write = 1'b0;
        rf_frame_err = 1'b0;
        rf_addr      = 8'h00;
        rf_wdata     = 32'h0000_0000;
    end

    // one command held over its taking edge; answer read just after that edge
    task automatic cmd(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic err,
                       output mbx_rsp_t code);
        @(posedge sys_clk);
        #1;
        rf_cmd_valid = 1'b1;
        rf_cmd_write = w;
        rf_frame_err = err;
        rf_addr      = a;
        rf_wdata     = d;
        @(posedge sys_clk);
        #1;
        rf_cmd_valid = 1'b0;
        // released lines must not keep showing the old value
        rf_addr      = ~a;
        rf_wdata     = ~d;
        code         = rf_rsp_valid ? rf_rsp_code : MBX_RSP_NONE;
    endtask

    // whole inbound message of four blocks, first FCh and last FFh
    task automatic send_msg(input logic [127:0] m, output mbx_rsp_t last);
        for (int i = 0; i < 4; i++) begin
            cmd(1'b1, MBX_ADDR_FIRST + 8'(i), m[32*i+:32], 1'b0, last);
        end
    endtask

    // poll FCh until the flags word says host data ready; bounded tries
    task automatic poll(output logic [127:0] data);
        mbx_rsp_t c;
        for (int i = 0; i < 20; i++) begin
            cmd(1'b0, MBX_ADDR_FIRST, 32'h0000_0000, 1'b0, c);
            if (rf_rsp_data[103:96] == 8'h01) break;
        end
        data = rf_rsp_data;
    endtask
endmodule

// ---- bench/tb_mbx_bridge.sv ----
// tb_mbx_bridge: self-checking bench for the reader/host mailbox bridge
`timescale 1ns/1ps
module tb_mbx_bridge
    import mbx_pkg::*;
;
    logic         sys_clk, rstn, ext_mode_en, tun_mode_en, rf_field_on;
    logic         rf_cmd_valid, rf_cmd_write, rf_frame_err, rf_rsp_valid;
    logic [7:0]   rf_addr, mbx_flags;
    logic [31:0]  rf_wdata, host_wdata, host_rd_data;
    mbx_rsp_t     rf_rsp_code, rc;
    logic [127:0] rf_rsp_data, msg, got;
    logic         host_cmd_valid, host_wr_valid, host_rd_valid, host_rd_done;
    mbx_cmd_t     host_cmd;
    logic [1:0]   host_idx;
    logic         rx_start_irq, rx_end_irq, tx_end_irq, acc_err_irq;
    logic         reader_owns_buf;
    int           miscompares, checks_done, seed;

    mbx_bridge mbx_bridge_i (.sys_clk(sys_clk), .rstn(rstn),
        .ext_mode_en(ext_mode_en), .tun_mode_en(tun_mode_en),
        .rf_field_on(rf_field_on), .rf_cmd_valid(rf_cmd_valid),
        .rf_cmd_write(rf_cmd_write), .rf_frame_err(rf_frame_err),
        .rf_addr(rf_addr), .rf_wdata(rf_wdata), .rf_rsp_valid(rf_rsp_valid),
        .rf_rsp_code(rf_rsp_code), .rf_rsp_data(rf_rsp_data),
        .host_cmd_valid(host_cmd_valid), .host_cmd(host_cmd),
        .host_wr_valid(host_wr_valid), .host_rd_valid(host_rd_valid),
        .host_idx(host_idx), .host_wdata(host_wdata),
        .host_rd_done(host_rd_done), .host_rd_data(host_rd_data),
        .rx_start_irq(rx_start_irq), .rx_end_irq(rx_end_irq),
        .tx_end_irq(tx_end_irq), .acc_err_irq(acc_err_irq),
        .mbx_flags(mbx_flags), .reader_owns_buf(reader_owns_buf));

    mbx_reader_model mbx_reader_model_i (.sys_clk(sys_clk),
        .rf_cmd_valid(rf_cmd_valid), .rf_cmd_write(rf_cmd_write),
        .rf_frame_err(rf_frame_err), .rf_addr(rf_addr), .rf_wdata(rf_wdata),
        .rf_rsp_valid(rf_rsp_valid), .rf_rsp_code(rf_rsp_code),
        .rf_rsp_data(rf_rsp_data));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [7:0] flg(input logic hr, hp, ra, rr);
        flg = 8'h00;
        flg[MBX_FLG_HOST_RDY]  = hr;
        flg[MBX_FLG_HOST_PEND] = hp;
        flg[MBX_FLG_RD_ACTIVE] = ra;
        flg[MBX_FLG_RD_RDY]    = rr;
    endfunction

    task automatic chk(input string nm, input logic [127:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic rcmd(input logic w, input logic [7:0] a,
                        input logic [31:0] d, input logic err);
        mbx_reader_model_i.cmd(w, a, d, err, rc);
    endtask

    // host request held over its taking edge; pulses read just after it
    task automatic hreq(input logic c, w, r, input mbx_cmd_t cm,
                        input logic [1:0] ix, input logic [31:0] d);
        @(posedge sys_clk);
        #1;
        host_cmd_valid = c;
        host_wr_valid  = w;
        host_rd_valid  = r;
        host_cmd       = cm;
        host_idx       = ix;
        host_wdata     = d;
        @(posedge sys_clk);
        #1;
        host_cmd_valid = 1'b0;
        host_wr_valid  = 1'b0;
        host_rd_valid  = 1'b0;
        host_wdata     = ~d;
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ************************************************************
    // clock, watchdog and sequence
    // ************************************************************
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // the sequence needs about 200 cycles; a hundred times that is a hang
    initial begin
        #(40 * 20000);
        miscompares++;
        end_of_test();
    end

    initial begin
        seed = 21389;
        {rstn, tun_mode_en, rf_field_on, host_cmd_valid} = 4'h0;
        {host_wr_valid, host_rd_valid, host_idx} = 4'h0;
        ext_mode_en = 1'b1;
        host_cmd = MBX_CMD_NOP;
        host_wdata = 32'h0000_0000;
        repeat (20) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        @(posedge sys_clk);
        #1;
        rf_field_on = 1'b1;
        repeat (4) @(posedge sys_clk);
        #1;
        chk("flags_rst", mbx_flags, MBX_FLAGS_RST);
        rcmd(1'b1, MBX_ADDR_LAST, 32'h0000_0000, 1'b0);
        chk("ff_first", rc, MBX_RSP_NAK);
        for (int k = 0; k < 3; k++) begin
            msg = {$random(seed), $random(seed), $random(seed), $random(seed)};
            rcmd(1'b1, MBX_ADDR_FIRST, msg[31:0], 1'b0);
            chk("rx_ack", rc, MBX_RSP_ACK);
            chk("rx_start", rx_start_irq, 1'b1);
            chk("rx_flags", mbx_flags, flg(0, 0, 1, 0));
            chk("rx_owner", reader_owns_buf, 1'b1);
            hreq(0, 1, 1, MBX_CMD_NOP, 2'h0, 0);
            chk("rx_block", acc_err_irq, 1'b1);
            rcmd(1'b0, MBX_ADDR_FIRST, 32'h0000_0000, 1'b0);
            chk("stat_rd", rf_rsp_data[127:96], flg(0, 0, 1, 0));
            rcmd(1'b1, MBX_ADDR_MID1, msg[63:32], 1'b0);
            rcmd(1'b1, MBX_ADDR_MID2, msg[95:64], 1'b0);
            rcmd(1'b1, MBX_ADDR_LAST, msg[127:96], 1'b0);
            chk("rx_end", rx_end_irq, 1'b1);
            chk("rx_rdy", mbx_flags, flg(0, 0, 0, 1));
            rcmd(1'b1, MBX_ADDR_FIRST, 32'h0000_0000, 1'b0);
            chk("rdy_nak", rc, MBX_RSP_NAK);
            for (int i = 0; i < 4; i++) begin
                hreq(0, 0, 1, MBX_CMD_NOP, 2'(i), 0);
                chk("h_rd", host_rd_data, msg[32*i+:32]);
                chk("h_done", host_rd_done, 1'b1);
            end
            hreq(1, 0, 0, MBX_CMD_CLEAR, 2'h0, 0);
            chk("clr", mbx_flags, flg(0, 1, 0, 0));
            rcmd(1'b0, MBX_ADDR_FIRST, 32'h0000_0000, 1'b0);
            chk("early", rf_rsp_data, {flg(0, 1, 0, 0), 96'h0});
            hreq(0, 1, 0, MBX_CMD_NOP, 2'h3, 0);
            chk("wr_idx3", acc_err_irq, 1'b1);
            for (int i = 0; i < 3; i++) begin
                hreq(0, 1, 0, MBX_CMD_NOP, 2'(i), msg[32*i+:32]);
                chk("h_wr", acc_err_irq, 1'b0);
            end
            hreq(1, 0, 0, MBX_CMD_TRANSMIT, 2'h0, 0);
            chk("tx_rdy", mbx_flags, flg(1, 0, 0, 0));
            hreq(0, 1, 0, MBX_CMD_NOP, 2'h0, 0);
            chk("h_refuse", acc_err_irq, 1'b1);
            rcmd(1'b0, MBX_ADDR_MID1, 32'h0000_0000, 1'b0);
            chk("rd_other", rc, MBX_RSP_NAK);
            mbx_reader_model_i.poll(got);
            chk("tx_data", got, {flg(1, 0, 0, 0), msg[95:0]});
            rcmd(1'b1, MBX_ADDR_LAST, 32'h0000_0000, 1'b0);
            chk("tx_end", tx_end_irq, 1'b1);
            chk("tx_idle", mbx_flags, MBX_FLAGS_RST);
            $display("message round %0d done", k);
        end
        rcmd(1'b1, MBX_ADDR_FIRST, 32'h1234_5678, 1'b1);
        chk("bad_frame", mbx_flags, MBX_FLAGS_RST);
        rcmd(1'b1, MBX_ADDR_FIRST, 32'h1234_5678, 1'b0);
        rcmd(1'b1, MBX_ADDR_MID1, 32'h9ABC_DEF0, 1'b0);
        rcmd(1'b1, 8'h10, 32'h0000_0001, 1'b0);
        chk("mem_wr", rc, MBX_RSP_EEPROM);
        hreq(0, 0, 1, MBX_CMD_NOP, 2'h0, 0);
        chk("discard", host_rd_data, 32'h0000_0000);
        $display("interleave test done");
        @(posedge sys_clk);
        #1;
        tun_mode_en = 1'b1;
        rcmd(1'b1, MBX_ADDR_FIRST, 32'h0000_0000, 1'b0);
        chk("tun_pri", rc, MBX_RSP_EEPROM);
        tun_mode_en = 1'b0;
        ext_mode_en = 1'b0;
        rcmd(1'b1, MBX_ADDR_FIRST, 32'h0000_0000, 1'b0);
        chk("ext_off", rc, MBX_RSP_EEPROM);
        ext_mode_en = 1'b1;
        $display("mode test done");
        mbx_reader_model_i.send_msg({4{$random(seed)}}, rc);
        chk("keep", mbx_flags, flg(0, 0, 0, 1));
        rf_field_on = 1'b0;
        repeat (4) @(posedge sys_clk);
        #1;
        rf_field_on = 1'b1;
        repeat (5) @(posedge sys_clk);
        #1;
        chk("fld_flags", mbx_flags, MBX_FLAGS_RST);
        hreq(0, 0, 1, MBX_CMD_NOP, 2'h0, 0);
        chk("fld_buf", host_rd_data, 32'h0000_0000);
        $display("field cycle test done");
        end_of_test();
    end
endmodule
